// File: core/wdpt_top.sv
// Prescaled watchdog timer: APB register block, prescaler and countdown.
// Assumes ref_clk is the crystal oscillator input, rst is power-on reset
// and sysReset is the chip reset; wdChipReset is routed to the chip reset.
`timescale 1ns/1ps
module wdpt_top (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sysReset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [wdpt_pkg::WDPT_ADDR_W-1:0] paddr,
    input wire logic [wdpt_pkg::WDPT_DATA_W-1:0] pwdata,
    output logic pready,
    output logic [wdpt_pkg::WDPT_DATA_W-1:0] prdata,
    output logic pslverr,
    output logic wdChipReset,
    output logic wdFired
);
    import wdpt_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    wdpt_tick_if tick ();                    // Link to prescaler and countdown
    logic clearAll;                          // Power-on or chip reset
    logic [1:0] control_reg;                 // Count and trigger enables
    logic [WDPT_PRE_W-1:0] divider_reg;      // Prescaler wrap value
    logic fired_reg;                         // Sticky fired flag
    logic chipReset_reg;                     // Chip reset request pulse
    logic [WDPT_DATA_W-1:0] prdata_reg;      // Read data for access phase
    logic pslverr_reg;                       // Error answer for access phase
    logic [WDPT_DATA_W-1:0] readWord;        // Read mux output
    logic setupPhase;                        // APB setup cycle
    logic accessPhase;                       // APB access cycle
    logic writeStrobe;                       // Write takes effect this edge
    logic countEnable;                       // Counting enable bit
    logic triggerEnable;                     // Chip reset enable bit

    // Address decode, shared by write path and error answer
    function automatic logic regHit(
        input logic [WDPT_ADDR_W-1:0] addr,
        input logic [WDPT_ADDR_W-1:0] target
    );
        regHit = (addr == target);
    endfunction : regHit

    // True for any mapped register address
    function automatic logic isMapped(input logic [WDPT_ADDR_W-1:0] addr);
        isMapped = regHit(addr, WDPT_ADDR_CONTROL) || regHit(addr, WDPT_ADDR_PRESCALE)
            || regHit(addr, WDPT_ADDR_DIVIDER) || regHit(addr, WDPT_ADDR_COUNTDOWN)
            || regHit(addr, WDPT_ADDR_STATUS);
    endfunction : isMapped

    // ************************************************************
    // Reset and bus phase decode
    // ************************************************************
    // Chip reset clears all but the fired flag and the captured read data and error answer
    assign clearAll = rst || sysReset;
    assign setupPhase = psel && !penable;
    assign accessPhase = psel && penable;
    // Zero wait states: ready whenever in access phase
    assign pready = accessPhase;
    assign writeStrobe = accessPhase && pwrite;
    assign countEnable = control_reg[WDPT_CTL_COUNT_EN_BIT];
    assign triggerEnable = control_reg[WDPT_CTL_TRIGGER_EN_BIT];

    // ************************************************************
    // Control register
    // ************************************************************
    // Holds count and trigger enables, both off after reset
    always_ff @(posedge ref_clk) begin
        if (clearAll) begin
            control_reg <= WDPT_CONTROL_RST;
        end else if (writeStrobe && regHit(paddr, WDPT_ADDR_CONTROL)) begin
            // Any combination allowed, counting-only included
            control_reg <= pwdata[1:0];
        end
    end

    // ************************************************************
    // Divider register
    // ************************************************************
    // Wrap value, all ones after reset
    always_ff @(posedge ref_clk) begin
        if (clearAll) begin
            divider_reg <= WDPT_DIVIDER_RST;
        end else if (writeStrobe && regHit(paddr, WDPT_ADDR_DIVIDER)) begin
            divider_reg <= pwdata[WDPT_PRE_W-1:0];
        end
    end

    // ************************************************************
    // Links to prescaler and countdown
    // ************************************************************
    assign tick.countEnable = countEnable;
    assign tick.divider = divider_reg;
    // Countdown write is the kick that keeps the chip alive
    assign tick.loadValid = writeStrobe && regHit(paddr, WDPT_ADDR_COUNTDOWN);
    assign tick.loadValue = pwdata[WDPT_CNT_W-1:0];

    // Prescaler
    wdpt_prescaler u_prescaler (
        .ref_clk(ref_clk),
        .clear(clearAll),
        .tick(tick.pre)
    );

    // Countdown
    wdpt_countdown u_countdown (
        .ref_clk(ref_clk),
        .clear(clearAll),
        .tick(tick.cdn)
    );

    // ************************************************************
    // Fired flag
    // ************************************************************
    // Set when expiry actually resets the chip; only power-on clears it
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            fired_reg <= WDPT_FIRED_RST;
        end else if (tick.expire && triggerEnable) begin
            fired_reg <= 1'b1;
        end
    end
    assign wdFired = fired_reg;

    // ************************************************************
    // Chip reset request
    // ************************************************************
    // One-cycle pulse on expiry when triggering is enabled
    always_ff @(posedge ref_clk) begin
        if (clearAll) begin
            chipReset_reg <= 1'b0;
        end else begin
            chipReset_reg <= tick.expire && triggerEnable;
        end
    end
    assign wdChipReset = chipReset_reg;

    // ************************************************************
    // Read mux
    // ************************************************************
    // Reserved bits read as zero
    always_comb begin
        readWord = 32'h0000_0000;
        case (paddr)
            WDPT_ADDR_CONTROL: begin
                readWord[1:0] = control_reg;
            end
            WDPT_ADDR_PRESCALE: begin
                readWord[WDPT_PRE_W-1:0] = tick.prescaleCount;
            end
            WDPT_ADDR_DIVIDER: begin
                readWord[WDPT_PRE_W-1:0] = divider_reg;
            end
            WDPT_ADDR_COUNTDOWN: begin
                readWord[WDPT_CNT_W-1:0] = tick.countdownValue;
            end
            WDPT_ADDR_STATUS: begin
                readWord[WDPT_STATUS_FIRED_BIT] = fired_reg;
            end
            default: begin
                readWord = 32'h0000_0000;
            end
        endcase
    end

    // ************************************************************
    // Read data and error answer
    // ************************************************************
    // Captured in the setup cycle so outputs come from flip-flops
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prdata_reg <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else if (setupPhase) begin
            prdata_reg <= pwrite ? 32'h0000_0000 : readWord;
            pslverr_reg <= !isMapped(paddr);
        end
    end
    assign prdata = prdata_reg;
    // Error only shown while the access completes
    assign pslverr = accessPhase && pslverr_reg;

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking tcb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // Status read, setup then access
    sequence sStatusRead;
        psel && !penable && !pwrite && paddr == WDPT_ADDR_STATUS ##1 psel && penable;
    endsequence

    // Prescaler read, setup then access
    sequence sPrescaleRead;
        psel && !penable && !pwrite && paddr == WDPT_ADDR_PRESCALE ##1 psel && penable;
    endsequence

    // Divider write not cut by chip reset
    sequence sDividerWrite;
        psel && !penable && pwrite && paddr == WDPT_ADDR_DIVIDER
        ##1 psel && penable && !sysReset;
    endsequence

    // Countdown write not cut by chip reset
    sequence sCountdownWrite;
        psel && !penable && pwrite && paddr == WDPT_ADDR_COUNTDOWN
        ##1 psel && penable && !sysReset;
    endsequence

    // Unmapped write not cut by chip reset
    sequence sUnmappedWrite;
        psel && !penable && pwrite && !isMapped(paddr) ##1 psel && penable && !sysReset;
    endsequence

    // Expiry allowed to reach the chip
    sequence sExpireArmed;
        tick.expire && triggerEnable && !sysReset;
    endsequence

    // Power-on reset values
    chk_ctl_after_reset: assert property (
        $fell(rst) |-> control_reg == 2'h0 && divider_reg == 16'hFFFF
        && tick.countdownValue == 12'hFFF && !fired_reg)
        else $error("reset values wrong after power-on");

    // Chip reset values, fired flag aside
    chk_sys_reset_values: assert property (
        $fell(sysReset) |-> control_reg == 2'h0 && divider_reg == 16'hFFFF
        && tick.countdownValue == 12'hFFF)
        else $error("reset values wrong after chip reset");

    // Armed expiry sets flag and pulses
    chk_fire_effects: assert property (
        sExpireArmed |=> fired_reg && wdChipReset)
        else $error("armed expiry did not fire");

    // No request while triggering is off
    chk_no_trigger: assert property (
        tick.expire && !triggerEnable |=> !wdChipReset)
        else $error("chip reset with triggering disabled");

    // Counting-only mode never resets
    chk_count_only: assert property (
        countEnable && !triggerEnable |=> !wdChipReset)
        else $error("chip reset in counting-only mode");

    // Only power-on clears the flag
    chk_fired_sticky: assert property (
        fired_reg |=> fired_reg)
        else $error("fired flag cleared without power-on reset");

    // Flag rises only on armed expiry
    chk_fired_cause: assert property (
        $rose(fired_reg) |-> $past(tick.expire && triggerEnable))
        else $error("fired flag set without armed expiry");

    // Status read shows the flag
    chk_status_read: assert property (
        sStatusRead |-> prdata == {31'h0000_0000, $past(fired_reg)})
        else $error("status read does not show fired flag");

    // Prescaler read shows the count
    chk_prescale_read: assert property (
        sPrescaleRead |-> prdata == {16'h0000, $past(tick.prescaleCount)})
        else $error("prescaler read does not show the count");

    // Disabled counting stays quiet
    chk_disabled_quiet: assert property (
        !countEnable |-> !tick.wrapTick && !tick.expire ##1 !$rose(fired_reg))
        else $error("activity while counting disabled");

    // Control write lands at completion
    chk_ctl_write: assert property (
        writeStrobe && regHit(paddr, WDPT_ADDR_CONTROL) && !sysReset
        |=> control_reg == $past(pwdata[1:0]))
        else $error("control write not taken");

    // Divider write lands at completion
    chk_div_write: assert property (
        sDividerWrite |=> divider_reg == $past(pwdata[WDPT_PRE_W-1:0]))
        else $error("divider write not taken");

    // Countdown write loads at once
    chk_cd_write: assert property (
        sCountdownWrite |=> tick.countdownValue == $past(pwdata[WDPT_CNT_W-1:0]))
        else $error("countdown write not loaded");

    // Unmapped access is refused
    chk_unmapped_err: assert property (
        psel && !penable && !isMapped(paddr) ##1 psel && penable |-> pslverr && pready)
        else $error("unmapped address not refused");

    // Unmapped write leaves control and divider unchanged
    chk_unmapped_write: assert property (
        sUnmappedWrite |=> $stable(control_reg) && $stable(divider_reg))
        else $error("unmapped write changed a register");

endmodule : wdpt_top

// File: inc/wdpt_pkg.sv
// Shared constants for the prescaled watchdog timer.
// Assumes one clock (the oscillator input) and word-wide APB access.
package wdpt_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int unsigned WDPT_ADDR_W = 20;  // APB byte address width
    localparam int unsigned WDPT_DATA_W = 32;  // APB data width
    localparam int unsigned WDPT_PRE_W = 16;   // Prescaler and divider width
    localparam int unsigned WDPT_CNT_W = 12;   // Countdown width

    // ************************************************************
    // Register indices and byte addresses (address = index * 4)
    // ************************************************************
    localparam logic [19:0] WDPT_IDX_CONTROL = 20'h0_F020;
    localparam logic [19:0] WDPT_IDX_PRESCALE = 20'h0_F021;
    localparam logic [19:0] WDPT_IDX_DIVIDER = 20'h0_F022;
    localparam logic [19:0] WDPT_IDX_COUNTDOWN = 20'h0_F023;
    localparam logic [19:0] WDPT_IDX_STATUS = 20'h0_F024;
    localparam logic [19:0] WDPT_ADDR_CONTROL = WDPT_IDX_CONTROL << 2;
    localparam logic [19:0] WDPT_ADDR_PRESCALE = WDPT_IDX_PRESCALE << 2;
    localparam logic [19:0] WDPT_ADDR_DIVIDER = WDPT_IDX_DIVIDER << 2;
    localparam logic [19:0] WDPT_ADDR_COUNTDOWN = WDPT_IDX_COUNTDOWN << 2;
    localparam logic [19:0] WDPT_ADDR_STATUS = WDPT_IDX_STATUS << 2;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int unsigned WDPT_CTL_COUNT_EN_BIT = 0;   // Counting enable
    localparam int unsigned WDPT_CTL_TRIGGER_EN_BIT = 1; // Chip reset enable
    localparam int unsigned WDPT_STATUS_FIRED_BIT = 0;   // Fired flag

    // ************************************************************
    // Values after reset
    // ************************************************************
    localparam logic [1:0] WDPT_CONTROL_RST = 2'h0;
    localparam logic [15:0] WDPT_PRESCALE_RST = 16'h0000;
    localparam logic [15:0] WDPT_DIVIDER_RST = 16'hFFFF;
    localparam logic [11:0] WDPT_COUNTDOWN_RST = 12'hFFF;
    localparam logic WDPT_FIRED_RST = 1'h0;

endpackage : wdpt_pkg

// File: inc/wdpt_tick_if.sv
// Carrier between the watchdog register block, prescaler and countdown.
// Assumes all three sit on the same oscillator clock.
`timescale 1ns/1ps
interface wdpt_tick_if;
    logic countEnable;                              // Counting enabled
    logic [wdpt_pkg::WDPT_PRE_W-1:0] divider;       // Prescaler wrap value
    logic [wdpt_pkg::WDPT_PRE_W-1:0] prescaleCount; // Live prescaler count
    logic wrapTick;                                 // Prescaler wraps now
    logic loadValid;                                // Software loads countdown
    logic [wdpt_pkg::WDPT_CNT_W-1:0] loadValue;     // Value to load
    logic [wdpt_pkg::WDPT_CNT_W-1:0] countdownValue; // Live countdown
    logic expire;                                   // Countdown hits zero now

    // Prescaler end
    modport pre (input countEnable, input divider, output prescaleCount, output wrapTick);
    // Countdown end
    modport cdn (input countEnable, input wrapTick, input loadValid, input loadValue,
                 output countdownValue, output expire);
    // Register block end
    modport ctl (output countEnable, output divider, output loadValid, output loadValue,
                 input prescaleCount, input wrapTick, input countdownValue, input expire);
endinterface : wdpt_tick_if

// File: core/wdpt_prescaler.sv
// Prescaler: counts oscillator edges and wraps at the divider value.
// Assumes clear is synchronous and covers both power-on and chip reset.
`timescale 1ns/1ps
module wdpt_prescaler (
    input wire logic ref_clk,
    input wire logic clear,
    wdpt_tick_if.pre tick
);
    import wdpt_pkg::*;

    logic [WDPT_PRE_W-1:0] prescale_reg; // Current prescaler count
    logic atWrap;                        // Count has reached the divider

    // ************************************************************
    // Wrap detection
    // ************************************************************
    // Compare with >= so a divider lowered below the count still wraps
    assign atWrap = (prescale_reg >= tick.divider);
    assign tick.wrapTick = tick.countEnable && atWrap;
    assign tick.prescaleCount = prescale_reg;

    // Count one per clock edge while enabled, else hold
    always_ff @(posedge ref_clk) begin
        if (clear) begin
            prescale_reg <= WDPT_PRESCALE_RST;
        end else if (tick.countEnable) begin
            if (atWrap) begin
                prescale_reg <= WDPT_PRESCALE_RST;
            end else begin
                prescale_reg <= prescale_reg + 16'h0001;
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking pcb @(posedge ref_clk); endclocking
    default disable iff (clear);

    chk_prescale_wrap: assert property (tick.wrapTick |=> prescale_reg == 16'h0000)
        else $error("prescaler did not return to zero after wrap");
    chk_prescale_hold: assert property (!tick.countEnable |=> $stable(prescale_reg))
        else $error("prescaler moved while counting disabled");
    chk_prescale_step: assert property (
        tick.countEnable && !atWrap |=> prescale_reg == $past(prescale_reg) + 16'h0001)
        else $error("prescaler did not step by one");

endmodule : wdpt_prescaler

// File: core/wdpt_countdown.sv
// Countdown: twelve-bit timeout counter, stepped once per prescaler wrap.
// Assumes load requests come from the register block in the write cycle.
`timescale 1ns/1ps
module wdpt_countdown (
    input wire logic ref_clk,
    input wire logic clear,
    wdpt_tick_if.cdn tick
);
    import wdpt_pkg::*;

    logic [WDPT_CNT_W-1:0] count_reg; // Prescaled periods remaining
    logic nearZero;                   // Next step reaches zero

    // ************************************************************
    // Expiry detection
    // ************************************************************
    // At one or already zero, a wrap means timeout
    assign nearZero = (count_reg <= 12'h001);
    assign tick.expire = tick.wrapTick && !tick.loadValid && nearZero;
    assign tick.countdownValue = count_reg;

    // Load wins over a decrement in the same cycle
    always_ff @(posedge ref_clk) begin
        if (clear) begin
            count_reg <= WDPT_COUNTDOWN_RST;
        end else if (tick.loadValid) begin
            count_reg <= tick.loadValue;
        end else if (tick.wrapTick && count_reg != 12'h000) begin
            count_reg <= count_reg - 12'h001;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking ccb @(posedge ref_clk); endclocking
    default disable iff (clear);

    chk_load_immediate: assert property (
        tick.loadValid |=> count_reg == $past(tick.loadValue))
        else $error("countdown did not take the written value");
    chk_countdown_step: assert property (
        tick.wrapTick && !tick.loadValid && count_reg != 12'h000
        |=> count_reg == $past(count_reg) - 12'h001)
        else $error("countdown did not step once per wrap");
    chk_countdown_idle: assert property (
        !tick.wrapTick && !tick.loadValid |=> $stable(count_reg))
        else $error("countdown moved without a wrap");

endmodule : wdpt_countdown

// File: tb/tb_watchdog_prescaled_timer.sv
// Self-checking bench for the prescaled watchdog timer top level.
// Assumes zero-wait APB, synchronous resets and wdChipReset as a one-cycle pulse.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin cmpCount++; if ((got) !== (ex)) begin nMismatch++; \
    $display("FAIL %s expected %h seen %h", nm, ex, got); end end
module tb_watchdog_prescaled_timer;
    import wdpt_pkg::*;
    // ************************************************************
    // Signals
    // ************************************************************
    logic ref_clk = 1'b0;   // Oscillator clock
    logic rst = 1'b1;       // Power-on reset
    logic sysReset = 1'b0;  // Chip reset
    logic psel = 1'b0;      // APB select
    logic penable = 1'b0;   // APB enable
    logic pwrite = 1'b0;    // APB direction
    logic [19:0] paddr = '0; // APB address
    logic [31:0] pwdata = '0; // APB write data
    logic pready;           // APB ready
    logic [31:0] prdata;    // APB read data
    logic pslverr;          // APB error
    logic wdChipReset;      // Chip reset request pulse
    logic wdFired;          // Sticky fired flag
    int nMismatch = 0;      // Mismatch count
    int cmpCount = 0;       // Comparison count
    int pulseCount = 0;     // Chip reset pulses seen
    logic [31:0] rd;        // Last read data
    logic err;              // Last error flag
    // ************************************************************
    // Design and clock
    // ************************************************************
    wdpt_top u_dut (.ref_clk(ref_clk), .rst(rst), .sysReset(sysReset), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .wdChipReset(wdChipReset), .wdFired(wdFired));
    // 200 MHz clock
    initial begin
        forever #2.5 ref_clk = ~ref_clk;
    end
    // Count cycles with chip reset requested
    always @(posedge ref_clk) begin
        if (wdChipReset === 1'b1) pulseCount++;
    end
    // ************************************************************
    // Tasks
    // ************************************************************
    // Verdict and end of run
    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", cmpCount, nMismatch);
        if (nMismatch == 0 && cmpCount > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : complete_run
    // One APB transfer, waits for pready with a bound
    task automatic apb(input logic wr, input logic [19:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) nMismatch++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // One-cycle chip reset or power-on reset
    task automatic pulse_reset(input logic por);
        @(posedge ref_clk);
        if (por) rst <= 1'b1;
        else sysReset <= 1'b1;
        @(posedge ref_clk);
        rst <= 1'b0;
        sysReset <= 1'b0;
    endtask : pulse_reset
    // Chip reset, then divider and countdown set up
    task automatic arm(input logic [11:0] cd, input logic [1:0] ctl);
        pulse_reset(1'b0);
        apb(1'b1, WDPT_ADDR_DIVIDER, 32'h0000_0003);
        apb(1'b1, WDPT_ADDR_COUNTDOWN, {20'h0_0000, cd});
        apb(1'b1, WDPT_ADDR_CONTROL, {30'h0000_0000, ctl});
    endtask : arm
    // ************************************************************
    // Scenarios
    // ************************************************************
    // Reset values, read-only writes, unmapped access
    task automatic test_reset_map();
        `CHK("fired", 1'b0, wdFired)
        apb(1'b0, WDPT_ADDR_CONTROL, '0);
        `CHK("control", 32'h0000_0000, rd)
        apb(1'b1, WDPT_ADDR_PRESCALE, 32'h0000_1234);
        apb(1'b0, WDPT_ADDR_PRESCALE, '0);
        `CHK("prescale", 32'h0000_0000, rd)
        apb(1'b0, WDPT_ADDR_DIVIDER, '0);
        `CHK("divider", 32'h0000_FFFF, rd)
        apb(1'b0, WDPT_ADDR_COUNTDOWN, '0);
        `CHK("countdown", 32'h0000_0FFF, rd)
        apb(1'b1, WDPT_ADDR_STATUS, 32'h0000_0001);
        apb(1'b0, WDPT_ADDR_STATUS, '0);
        `CHK("status", 32'h0000_0000, rd)
        apb(1'b0, WDPT_ADDR_STATUS + 20'h0_0004, '0);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 32'h0000_0000, rd)
        apb(1'b1, WDPT_ADDR_STATUS + 20'h0_0004, 32'h0000_0003);
        `CHK("unmapped write err", 1'b1, err)
        apb(1'b0, WDPT_ADDR_CONTROL, '0);
        `CHK("control kept", 32'h0000_0000, rd)
        repeat (20) @(posedge ref_clk);
        apb(1'b0, WDPT_ADDR_PRESCALE, '0);
        `CHK("idle prescale", 32'h0000_0000, rd)
    endtask : test_reset_map
    // Counting only: countdown runs out, nothing fires
    task automatic test_count_only();
        int p0;
        logic [31:0] w0;
        p0 = pulseCount;
        arm(12'h002, 2'b01);
        apb(1'b0, WDPT_ADDR_DIVIDER, '0);
        `CHK("divider written", 32'h0000_0003, rd)
        apb(1'b0, WDPT_ADDR_PRESCALE, '0);
        `CHK("prescale range", 1'b1, rd <= 32'h0000_0003)
        repeat (20) @(posedge ref_clk);
        apb(1'b0, WDPT_ADDR_COUNTDOWN, '0);
        `CHK("count only cd", 32'h0000_0000, rd)
        `CHK("count only fired", 1'b0, wdFired)
        `CHK("count only pulse", p0, pulseCount)
        apb(1'b1, WDPT_ADDR_CONTROL, 32'h0000_0000);
        apb(1'b0, WDPT_ADDR_PRESCALE, '0);
        w0 = rd;
        repeat (10) @(posedge ref_clk);
        apb(1'b0, WDPT_ADDR_PRESCALE, '0);
        `CHK("frozen prescale", w0, rd)
    endtask : test_count_only
    // Trigger without counting never fires
    task automatic test_trigger_only();
        int p0;
        p0 = pulseCount;
        arm(12'h001, 2'b10);
        repeat (30) @(posedge ref_clk);
        apb(1'b0, WDPT_ADDR_COUNTDOWN, '0);
        `CHK("trig only cd", 32'h0000_0001, rd)
        `CHK("trig only pulse", p0, pulseCount)
        apb(1'b1, WDPT_ADDR_COUNTDOWN, 32'h0000_05A5);
        apb(1'b0, WDPT_ADDR_COUNTDOWN, '0);
        `CHK("loaded cd", 32'h0000_05A5, rd)
    endtask : test_trigger_only
    // Regular rewrites keep the chip out of reset
    task automatic test_kick();
        int p0;
        p0 = pulseCount;
        arm(12'h003, 2'b11);
        repeat (8) apb(1'b1, WDPT_ADDR_COUNTDOWN, 32'h0000_0003);
        apb(1'b0, WDPT_ADDR_COUNTDOWN, '0);
        `CHK("kick cd", 1'b1, rd >= 32'h0000_0002)
        `CHK("kick pulse", p0, pulseCount)
        `CHK("kick fired", 1'b0, wdFired)
    endtask : test_kick
    // Full expiry: exact timing, pulse, sticky flag across chip reset
    task automatic test_expire();
        int n;
        n = 0;
        arm(12'h002, 2'b11);
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (wdChipReset !== 1'b1 && n < 40);
        `CHK("expiry cycles", 8, n)
        `CHK("fired", 1'b1, wdFired)
        @(posedge ref_clk);
        #1;
        `CHK("pulse width", 1'b0, wdChipReset)
        apb(1'b0, WDPT_ADDR_STATUS, '0);
        `CHK("status fired", 32'h0000_0001, rd)
        pulse_reset(1'b0);
        apb(1'b0, WDPT_ADDR_CONTROL, '0);
        `CHK("control after chip reset", 32'h0000_0000, rd)
        apb(1'b0, WDPT_ADDR_COUNTDOWN, '0);
        `CHK("cd after chip reset", 32'h0000_0FFF, rd)
        `CHK("fired kept", 1'b1, wdFired)
        pulse_reset(1'b1);
        apb(1'b0, WDPT_ADDR_STATUS, '0);
        `CHK("status after power-on", 32'h0000_0000, rd)
    endtask : test_expire
    // ************************************************************
    // Main sequence and watchdog
    // ************************************************************
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        test_reset_map();
        test_count_only();
        test_trigger_only();
        test_kick();
        test_expire();
        complete_run();
    end
    // Cut a hang short
    initial begin
        repeat (5000) @(posedge ref_clk);
        nMismatch++;
        complete_run();
    end
endmodule : tb_watchdog_prescaled_timer
